// >>> core/omc_pkg.sv
// package: constants and types of the operating mode controller
package omc_pkg;
	// mode state encodings (one-hot)
	typedef enum logic [5:0] {
		OMC_RUN   = 6'h01,
		OMC_BDM   = 6'h02,
		OMC_WAIT  = 6'h04,
		OMC_STOP3 = 6'h08,
		OMC_STOP2 = 6'h10,
		OMC_STOP1 = 6'h20
	} omc_mode_e;

	// register byte offsets
	localparam logic [7:0] OMC_CTRL_OFF = 8'h00;
	localparam logic [7:0] OMC_STAT_OFF = 8'h04;
	localparam logic [7:0] OMC_CMD_OFF  = 8'h08;
	localparam logic [7:0] OMC_VEC_OFF  = 8'h0c;

	// control register bit positions
	localparam int OMC_CTRL_STOP_ALLOW_BIT = 0;
	localparam int OMC_CTRL_DEBUG_KEEPALIVE_BIT = 1;
	localparam int OMC_CTRL_VOLTAGE_DETECT_ON  = 2;
	localparam int OMC_CTRL_VOLTAGE_DETECT_IN_STOP = 3;
	localparam int OMC_CTRL_PDC   = 4;
	localparam int OMC_CTRL_PARTIAL_POWERDOWN_SELECT  = 5;
	localparam int OMC_CTRL_ACK   = 6;
	localparam int OMC_CTRL_W     = 6;

	// debug command codes
	localparam logic [3:0] OMC_CMD_MEM    = 4'h1;
	localparam logic [3:0] OMC_CMD_MEMST  = 4'h2;
	localparam logic [3:0] OMC_CMD_DBGREG = 4'h3;
	localparam logic [3:0] OMC_CMD_BKGND  = 4'h4;
	localparam logic [3:0] OMC_CMD_CPUREG = 4'h5;
	localparam logic [3:0] OMC_CMD_TRACE  = 4'h6;
	localparam logic [3:0] OMC_CMD_GO     = 4'h7;

	// reset vector location
	localparam logic [15:0] OMC_RESET_VEC = 16'hfffe;

	// command answer codes
	localparam logic [1:0] OMC_ANS_ACC   = 2'h1;
	localparam logic [1:0] OMC_ANS_REJ   = 2'h2;
	localparam logic [1:0] OMC_ANS_STERR = 2'h3;
endpackage

// >>> core/omc_top.sv
// file: operating mode controller with apb register slave
//
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/1ns
module omc_top (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        por_pulse,
	input  wire logic        debug_force_reset,
	input  wire logic        debug_mode_select_pin,
	input  wire logic        wait_instr,
	input  wire logic        stop_instr,
	input  wire logic        enter_debug_instruction,
	input  wire logic        dbg_breakpoint,
	input  wire logic        brk_breakpoint,
	input  wire logic        irq_req,
	input  wire logic        reset_pin_req,
	input  wire logic        wake_rti,
	input  wire logic        wake_lvd,
	input  wire logic        wake_adc,
	input  wire logic        wake_irq,
	input  wire logic        wake_kbi,
	output logic             cpu_clk_en_ff,
	output logic             bus_clk_en_ff,
	output logic             debug_clk_en_ff,
	output logic             regulator_full_ff,
	output logic             io_latch_ff,
	output logic             illegal_op_reset_ff,
	output logic             clear_int_mask_ff,
	output logic             take_vector_ff,
	output logic [15:0]      vector_addr_ff,
	output logic [5:0]       mode_ff
);
	// ****************************************************************
	// state
	// ****************************************************************
	omc_pkg::omc_mode_e  state_ff;
	omc_pkg::omc_mode_e  nxt_state;
	logic [omc_pkg::OMC_CTRL_W-1:0] ctrl_ff;
	logic                partial_powerdown_flag_ff;
	logic [1:0]          answer_ff;
	logic [3:0]          last_cmd_ff;
	logic [5:0]          stop_sel_ff;
	logic                wr_en;
	logic                rd_en;
	logic                cmd_wr;
	logic [3:0]          cmd;
	logic                bkgnd_cmd;
	logic                bdm_ok;
	logic                rst_vec_ev;
	logic                int_vec_ev;
	logic [15:0]         vec_src;
	omc_pkg::omc_mode_e  nxt_mode;
	logic [5:0]          sel_now;

	assign wr_en  = psel & penable & pwrite;
	assign rd_en  = psel & penable & ~pwrite;
	assign cmd_wr = wr_en & (paddr == omc_pkg::OMC_CMD_OFF);
	assign cmd    = pwdata[3:0];
	assign bdm_ok = ctrl_ff[omc_pkg::OMC_CTRL_DEBUG_KEEPALIVE_BIT];
	assign bkgnd_cmd = cmd_wr & (cmd == omc_pkg::OMC_CMD_BKGND);

	// decide answer to a debug command in a given mode
	function automatic logic [1:0] cmd_answer(input omc_pkg::omc_mode_e m,
			input logic [3:0] c);
		logic nonintr;
		logic active;
		nonintr = (c == omc_pkg::OMC_CMD_MEM) ||
			(c == omc_pkg::OMC_CMD_MEMST) ||
			(c == omc_pkg::OMC_CMD_DBGREG) ||
			(c == omc_pkg::OMC_CMD_BKGND);
		active = (c == omc_pkg::OMC_CMD_CPUREG) ||
			(c == omc_pkg::OMC_CMD_TRACE) ||
			(c == omc_pkg::OMC_CMD_GO);
		cmd_answer = omc_pkg::OMC_ANS_REJ;
		if (m == omc_pkg::OMC_BDM) begin
			if (nonintr || active)
				cmd_answer = omc_pkg::OMC_ANS_ACC;
		end else if (m == omc_pkg::OMC_RUN) begin
			if (nonintr)
				cmd_answer = omc_pkg::OMC_ANS_ACC;
		end else if (c == omc_pkg::OMC_CMD_MEMST) begin
			cmd_answer = omc_pkg::OMC_ANS_STERR;
		end else if (c == omc_pkg::OMC_CMD_BKGND) begin
			cmd_answer = omc_pkg::OMC_ANS_ACC;
		end
	endfunction

	// stop mode choice from sampled selection bits
	function automatic omc_pkg::omc_mode_e stop_pick(input logic [5:0] s);
		stop_pick = omc_pkg::OMC_STOP3;
		if (!s[omc_pkg::OMC_CTRL_DEBUG_KEEPALIVE_BIT] &&
				!(s[omc_pkg::OMC_CTRL_VOLTAGE_DETECT_ON] &&
				s[omc_pkg::OMC_CTRL_VOLTAGE_DETECT_IN_STOP]) &&
				s[omc_pkg::OMC_CTRL_PDC])
			stop_pick = s[omc_pkg::OMC_CTRL_PARTIAL_POWERDOWN_SELECT] ?
				omc_pkg::OMC_STOP2 : omc_pkg::OMC_STOP1;
	endfunction

	// modes in which the bus clock and full regulation stay on
	function automatic logic awake(input omc_pkg::omc_mode_e m);
		awake = (m == omc_pkg::OMC_RUN) || (m == omc_pkg::OMC_BDM) ||
			(m == omc_pkg::OMC_WAIT);
	endfunction

	// offsets that hold a register
	function automatic logic mapped(input logic [7:0] a);
		mapped = (a == omc_pkg::OMC_CTRL_OFF) ||
			(a == omc_pkg::OMC_STAT_OFF) ||
			(a == omc_pkg::OMC_CMD_OFF) ||
			(a == omc_pkg::OMC_VEC_OFF);
	endfunction

	// ****************************************************************
	// mode sequencing
	// ****************************************************************
	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			omc_pkg::OMC_RUN: begin
				if (bdm_ok && (bkgnd_cmd || enter_debug_instruction ||
						dbg_breakpoint || brk_breakpoint))
					nxt_state = omc_pkg::OMC_BDM;
				else if (stop_instr && ctrl_ff[omc_pkg::OMC_CTRL_STOP_ALLOW_BIT])
					nxt_state = stop_pick(ctrl_ff[5:0]);
				else if (wait_instr)
					nxt_state = omc_pkg::OMC_WAIT;
			end
			omc_pkg::OMC_BDM: begin
				if (cmd_wr && cmd == omc_pkg::OMC_CMD_GO)
					nxt_state = omc_pkg::OMC_RUN;
			end
			omc_pkg::OMC_WAIT: begin
				if (bkgnd_cmd)
					nxt_state = omc_pkg::OMC_BDM;
				else if (irq_req)
					nxt_state = omc_pkg::OMC_RUN;
			end
			omc_pkg::OMC_STOP3: begin
				if (reset_pin_req || int_vec_ev)
					nxt_state = omc_pkg::OMC_RUN;
				else if (bkgnd_cmd && stop_sel_ff[omc_pkg::OMC_CTRL_DEBUG_KEEPALIVE_BIT])
					nxt_state = omc_pkg::OMC_BDM;
			end
			omc_pkg::OMC_STOP2,
			omc_pkg::OMC_STOP1: begin
				if (reset_pin_req || wake_rti)
					nxt_state = omc_pkg::OMC_RUN;
			end
		endcase
	end

	assign int_vec_ev = wake_rti | wake_lvd | wake_adc | wake_irq | wake_kbi;
	assign rst_vec_ev = (state_ff != omc_pkg::OMC_RUN) &&
		(state_ff != omc_pkg::OMC_BDM) && (state_ff != omc_pkg::OMC_WAIT) &&
		nxt_state == omc_pkg::OMC_RUN &&
		(reset_pin_req || state_ff != omc_pkg::OMC_STOP3);
	assign vec_src = rst_vec_ev ? omc_pkg::OMC_RESET_VEC :
		{10'h3ff, pwdata[5:0]};

	// power-on and debug-forced resets override the sequencer; the
	// mode mirror, clock and regulator outputs follow this value so they never lag the mode by a cycle
	always_comb begin
		nxt_mode = nxt_state;
		if (por_pulse || debug_force_reset)
			nxt_mode = (!debug_mode_select_pin || debug_force_reset) ?
				omc_pkg::OMC_BDM : omc_pkg::OMC_RUN;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			state_ff <= omc_pkg::OMC_RUN;
		else
			state_ff <= nxt_mode;
	end

	// selection bits captured as the stop instruction executes
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			stop_sel_ff <= 6'h00;
		else if (state_ff == omc_pkg::OMC_RUN && stop_instr)
			stop_sel_ff <= ctrl_ff[5:0];
	end

	// ****************************************************************
	// clock, regulator and retention outputs
	// ****************************************************************
	// selection bits in force for the mode being entered, so the
	// stop entry edge already uses the freshly sampled set
	assign sel_now = (state_ff == omc_pkg::OMC_RUN && stop_instr) ?
		ctrl_ff : stop_sel_ff;

	// mode mirror for the outside
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			mode_ff <= omc_pkg::OMC_RUN;
		else
			mode_ff <= nxt_mode;
	end

	// cpu clock runs in run mode only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			cpu_clk_en_ff <= 1'b1;
		else
			cpu_clk_en_ff <= (nxt_mode == omc_pkg::OMC_RUN);
	end

	// bus clock halts in every stop mode; state is simply held
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			bus_clk_en_ff <= 1'b1;
		else
			bus_clk_en_ff <= awake(nxt_mode);
	end

	// debug logic keeps its clock in stop when debug was enabled
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			debug_clk_en_ff <= 1'b1;
		else
			debug_clk_en_ff <= awake(nxt_mode) ||
				sel_now[omc_pkg::OMC_CTRL_DEBUG_KEEPALIVE_BIT];
	end

	// regulator leaves full regulation only in a plain stop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			regulator_full_ff <= 1'b1;
		else
			regulator_full_ff <= awake(nxt_mode) ||
				sel_now[omc_pkg::OMC_CTRL_DEBUG_KEEPALIVE_BIT] ||
				(sel_now[omc_pkg::OMC_CTRL_VOLTAGE_DETECT_ON] &&
				sel_now[omc_pkg::OMC_CTRL_VOLTAGE_DETECT_IN_STOP]);
	end

	// stop2 wake flag and io latch held until acknowledged
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			partial_powerdown_flag_ff     <= 1'b0;
			io_latch_ff <= 1'b0;
		end else if (state_ff == omc_pkg::OMC_STOP2 &&
				nxt_state == omc_pkg::OMC_RUN) begin
			partial_powerdown_flag_ff     <= 1'b1;
			io_latch_ff <= 1'b1;
		end else if (nxt_state == omc_pkg::OMC_STOP2) begin
			io_latch_ff <= 1'b1;
		end else if (wr_en && paddr == omc_pkg::OMC_CTRL_OFF &&
				pwdata[omc_pkg::OMC_CTRL_ACK]) begin
			partial_powerdown_flag_ff     <= 1'b0;
			io_latch_ff <= 1'b0;
		end
	end

	// ****************************************************************
	// cpu side events
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			illegal_op_reset_ff <= 1'b0;
			clear_int_mask_ff   <= 1'b0;
			take_vector_ff      <= 1'b0;
			vector_addr_ff      <= 16'h0000;
		end else begin
			illegal_op_reset_ff <= state_ff == omc_pkg::OMC_RUN &&
				stop_instr && !ctrl_ff[omc_pkg::OMC_CTRL_STOP_ALLOW_BIT];
			clear_int_mask_ff <= state_ff == omc_pkg::OMC_RUN &&
				nxt_state == omc_pkg::OMC_WAIT;
			take_vector_ff <= (state_ff != omc_pkg::OMC_RUN &&
				state_ff != omc_pkg::OMC_BDM &&
				nxt_state == omc_pkg::OMC_RUN) ||
				por_pulse;
			if (por_pulse || rst_vec_ev)
				vector_addr_ff <= omc_pkg::OMC_RESET_VEC;
			else if (nxt_state == omc_pkg::OMC_RUN &&
					state_ff != omc_pkg::OMC_RUN)
				vector_addr_ff <= vec_src;
		end
	end

	// ****************************************************************
	// apb registers
	// ****************************************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ctrl_ff <= '0;
		else if (wr_en && paddr == omc_pkg::OMC_CTRL_OFF)
			ctrl_ff <= pwdata[omc_pkg::OMC_CTRL_W-1:0];
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			answer_ff   <= 2'h0;
			last_cmd_ff <= 4'h0;
		end else if (cmd_wr) begin
			answer_ff   <= cmd_answer(state_ff, cmd);
			last_cmd_ff <= cmd;
		end
	end

	// ready answers every setup cycle one clock later
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pready <= 1'b0;
		else
			pready <= psel & ~penable;
	end

	// unmapped offsets answer with an error alongside ready
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			pslverr <= 1'b0;
		else
			pslverr <= psel & ~penable & ~mapped(paddr);
	end

	// read word captured in the setup cycle, shown with ready
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
		end else begin
			prdata <= 32'h0;
			if (psel && !penable) begin
				unique case (paddr)
					omc_pkg::OMC_CTRL_OFF: prdata <= {26'h0, ctrl_ff[5:0]};
					omc_pkg::OMC_STAT_OFF: prdata <= {25'h0, partial_powerdown_flag_ff,
						state_ff};
					omc_pkg::OMC_CMD_OFF: prdata <= {26'h0, answer_ff,
						last_cmd_ff};
					omc_pkg::OMC_VEC_OFF: prdata <= {16'h0, vector_addr_ff};
					default: prdata <= 32'h0;
				endcase
			end
		end
	end
endmodule

// >>> verif/omc_host.sv
// apb master standing in for the external debug host
`timescale 1ns/1ns
module omc_host (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        go,
	input  wire logic        wr,
	input  wire logic [7:0]  adr,
	input  wire logic [31:0] wd,
	output logic             done,
	output logic [31:0]      rd,
	output logic             err,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [7:0]       paddr,
	output logic [31:0]      pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			psel <= 1'b0;
			penable <= 1'b0;
			done <= 1'b0;
			pwdata <= 32'h0;
		end else begin
			done <= 1'b0;
			if (psel && penable && pready) begin
				psel <= 1'b0;
				penable <= 1'b0;
				done <= 1'b1;
				rd <= prdata;
				err <= pslverr;
				// released data lines do not keep the last value
				pwdata <= ~pwdata;
			end else if (psel) begin
				penable <= 1'b1;
			end else if (go && !done) begin
				psel <= 1'b1;
				pwrite <= wr;
				paddr <= adr;
				pwdata <= wd;
			end
		end
	end
endmodule

// >>> verif/omc_monitor.sv
// port relations of the mode controller
`timescale 1ns/1ns
module omc_monitor (
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        por_pulse,
	input wire logic        debug_mode_select_pin,
	input wire logic        wait_instr,
	input wire logic        irq_req,
	input wire logic        wake_rti,
	input wire logic        reset_pin_req,
	input wire logic        cpu_clk_en_ff,
	input wire logic        bus_clk_en_ff,
	input wire logic        clear_int_mask_ff,
	input wire logic        take_vector_ff,
	input wire logic [15:0] vector_addr_ff,
	input wire logic [5:0]  mode_ff
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_stop_clk; |mode_ff[5:3] |-> !cpu_clk_en_ff && !bus_clk_en_ff; endproperty
	a_stop_clk: assert property (p_stop_clk) else $error("clock in stop");
	property p_wait_clk; mode_ff == 6'h04 |-> !cpu_clk_en_ff && bus_clk_en_ff; endproperty
	a_wait_clk: assert property (p_wait_clk) else $error("wait clocks");
	property p_bdm_cpu; mode_ff == 6'h02 |-> !cpu_clk_en_ff; endproperty
	a_bdm_cpu: assert property (p_bdm_cpu) else $error("cpu runs in bdm");
	property p_wait_mask; mode_ff == 6'h01 && wait_instr |-> ##[1:2] clear_int_mask_ff; endproperty
	a_wait_mask: assert property (p_wait_mask) else $error("mask kept");
	property p_wait_irq; mode_ff == 6'h04 && irq_req |-> ##[1:2] mode_ff == 6'h01; endproperty
	a_wait_irq: assert property (p_wait_irq) else $error("no wait exit");
	property p_s3_wake; mode_ff == 6'h08 && wake_rti |-> ##[1:2] take_vector_ff; endproperty
	a_s3_wake: assert property (p_s3_wake) else $error("no wake vector");
	property p_s3_rst;
		mode_ff == 6'h08 && reset_pin_req |-> ##[1:2] mode_ff == 6'h01 && vector_addr_ff == 16'hfffe;
	endproperty
	a_s3_rst: assert property (p_s3_rst) else $error("no reset exit");
	property p_por_bdm; por_pulse && !debug_mode_select_pin |-> ##[1:2] mode_ff == 6'h02; endproperty
	a_por_bdm: assert property (p_por_bdm) else $error("no bdm at por");
	c_stop2: cover property (mode_ff == 6'h10);
	c_stop1: cover property (mode_ff == 6'h20);
	c_wirq: cover property (mode_ff == 6'h04 && irq_req);
endmodule
bind omc_top omc_monitor u_mon (.pclk(pclk), .presetn(presetn), .por_pulse(por_pulse),
	.debug_mode_select_pin(debug_mode_select_pin), .wait_instr(wait_instr),
	.irq_req(irq_req), .wake_rti(wake_rti), .reset_pin_req(reset_pin_req),
	.cpu_clk_en_ff(cpu_clk_en_ff), .bus_clk_en_ff(bus_clk_en_ff),
	.clear_int_mask_ff(clear_int_mask_ff), .take_vector_ff(take_vector_ff),
	.vector_addr_ff(vector_addr_ff), .mode_ff(mode_ff));

// >>> verif/omc_tb.sv
// self-checking bench of the mode controller
`timescale 1ns/1ns
module omc_tb;
	logic pclk = 0, presetn = 0, go = 0, wr = 0, pin = 1, irq = 0, ill_seen;
	logic psel, penable, pwrite, pready, pslverr, done, err;
	logic cpu_c, bus_c, dbg_c, reg_f, io_l, ill, cim, tv;
	logic [7:0] paddr, adr = 0;
	logic [31:0] pwdata, prdata, rd, wd = 0;
	logic [12:0] ev = 0;
	logic [15:0] vec;
	logic [5:0] mode, c;
	int n_errors = 0, total_checks = 0, cyc = 0, seed = 36, em, i, k;
	omc_host u_host (.pclk(pclk), .presetn(presetn), .go(go), .wr(wr), .adr(adr),
		.wd(wd), .done(done), .rd(rd), .err(err), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr));
	omc_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .por_pulse(ev[0]),
		.debug_force_reset(ev[1]), .debug_mode_select_pin(pin),
		.wait_instr(ev[2]), .stop_instr(ev[3]), .enter_debug_instruction(ev[4]),
		.dbg_breakpoint(ev[5]), .brk_breakpoint(ev[6]), .irq_req(irq),
		.reset_pin_req(ev[7]), .wake_rti(ev[8]), .wake_lvd(ev[9]),
		.wake_adc(ev[10]), .wake_irq(ev[11]), .wake_kbi(ev[12]),
		.cpu_clk_en_ff(cpu_c), .bus_clk_en_ff(bus_c), .debug_clk_en_ff(dbg_c),
		.regulator_full_ff(reg_f), .io_latch_ff(io_l), .illegal_op_reset_ff(ill),
		.clear_int_mask_ff(cim), .take_vector_ff(tv), .vector_addr_ff(vec),
		.mode_ff(mode));
	initial begin
		forever #5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (ill === 1'b1) ill_seen <= 1'b1;
		if (cyc == 30000) begin
			n_errors++;
			give_verdict;
		end
	end
	task give_verdict;
		if (n_errors == 0 && total_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] s, input logic [31:0] e);
		total_checks++;
		if (s !== e) begin
			n_errors++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk) go <= 1'b1;
		wr <= w;
		adr <= a;
		wd <= d;
		do @(posedge pclk); while (done !== 1'b1);
		go <= 1'b0;
	endtask
	task fire(input int b);
		@(posedge pclk) ev <= 13'h1 << b;
		@(posedge pclk) ev <= 13'h0;
		repeat (3) @(posedge pclk);
	endtask
	task stat(input int m);
		bus(1'b0, 8'h04, 32'h0);
		chk(rd[5:0], m[5:0]);
	endtask
	// answer model: 1 accepted, 2 rejected, 3 stop or wait error
	function int ans(input int m, input int cd);
		if (m == 2) return 1;
		if (m == 1) return (cd <= 4) ? 1 : 2;
		return (cd == 2) ? 3 : (cd == 4) ? 1 : 2;
	endfunction
	task cmd(input int cd, input int m);
		bus(1'b1, 8'h08, cd);
		bus(1'b0, 8'h08, 32'h0);
		chk(rd[5:4], ans(m, cd) & 3);
	endtask
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		pin <= 1'b0;
		fire(0);
		pin <= 1'b1;
		stat(2);
		for (k = 1; k <= 7; k++) cmd(k, 2);
		stat(1);
		for (k = 1; k <= 7; k++) if (k != 4) cmd(k, 1);
		bus(1'b0, 8'h10, 32'h0);
		chk(err, 1);
		chk(rd, 0);
		fire(4);
		stat(1);
		bus(1'b1, 8'h00, 32'h42);
		for (k = 4; k <= 6; k++) begin
			fire(k);
			stat(2);
			cmd(7, 2);
		end
		cmd(4, 1);
		stat(2);
		cmd(7, 2);
		pin <= 1'b0;
		fire(1);
		pin <= 1'b1;
		stat(2);
		cmd(7, 2);
		fire(2);
		stat(4);
		cmd(2, 4);
		cmd(1, 4);
		cmd(4, 4);
		stat(2);
		cmd(7, 2);
		fire(2);
		@(posedge pclk) irq <= 1'b1;
		repeat (3) @(posedge pclk) irq <= 1'b0;
		stat(1);
		for (i = 0; i < 64; i++) begin
			c = i[5:0];
			bus(1'b1, 8'h00, {25'h0, 1'b1, c});
			em = !c[0] ? 1 : (c[1] || (c[2] && c[3]) || !c[4]) ? 8 : c[5] ? 16 : 32;
			ill_seen = 1'b0;
			fire(3);
			stat(em);
			chk(ill_seen, !c[0]);
			if (em != 1) begin
				chk(reg_f, c[1] | (c[2] & c[3]));
				chk(dbg_c, c[1]);
				chk(cpu_c | bus_c, 0);
				if (c[1]) begin
					cmd(2, 8);
					cmd(4, 8);
					stat(2);
					cmd(7, 2);
				end else begin
					k = (em == 8) ? 7 + ($unsigned($random(seed)) % 6) : 7;
					fire(k);
					stat(1);
					if (k == 7) chk(vec, 16'hfffe);
					else chk(vec[15:6], 10'h3ff);
					if (em == 16) begin
						bus(1'b0, 8'h04, 32'h0);
						chk(rd[6], 1);
						chk(io_l, 1);
						bus(1'b1, 8'h00, 32'h40);
						bus(1'b0, 8'h04, 32'h0);
						chk(rd[6], 0);
						chk(io_l, 0);
					end
				end
			end
		end
		give_verdict;
	end
endmodule
